/* core/fcs_cfg.svh */
// Register map, field positions, reset values and frequency codes
// for the fan setup register bank. Definitions only.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

`define FCS_ADDR_ENH 8'h45
`define FCS_ADDR_PRC 8'h4A
`define FCS_ADDR_SPIN 8'h4B
`define FCS_ADDR_DUTY 8'h4C
`define FCS_ADDR_FREQ 8'h4D
`define FCS_ADDR_LOFS 8'h4E
`define FCS_ADDR_LUT_LO 8'h4F
`define FCS_ADDR_LUT_HI 8'h67
`define FCS_ADDR_TRUE 8'h30
`define FCS_ADDR_SLSB 8'h10
`define FCS_ADDR_POR 8'h33
`define FCS_ADDR_CONF 8'h03
`define FCS_ADDR_CONF_M 8'h09

`define FCS_RST_ENH 8'h00
`define FCS_RST_PRC 8'h20
`define FCS_RST_SPIN 8'h3F
`define FCS_RST_FREQ 8'h17
`define FCS_RST_DUTY 8'h00
`define FCS_RST_LOFS 8'h00
`define FCS_RST_TRUE 8'h02
`define FCS_RST_CONF 8'h00

`define FCS_BIT_PGM 5
`define FCS_BIT_CLKSEL 3
`define FCS_BIT_SFBE 6
`define FCS_BIT_LUT_RESOLUTION_EXTEND 5
`define FCS_BIT_HIRES 4
`define FCS_BIT_NRDY 7

`define FCS_MASK_ENH 8'h7F
`define FCS_MASK_PRC 8'h3B
`define FCS_MASK_SPIN 8'h3F
`define FCS_MASK_FREQ 8'h1F
`define FCS_MASK_DUTY_LO 8'h3F
`define FCS_MASK_DUTY_HI 8'hFF
`define FCS_MASK_SLSB_FILT 8'h18

// Frequency code 0x17 with the fast clock deselected gives 22.5 kHz
`define FCS_FREQ_HIGHRES 5'h17
`define FCS_LUT_DEPTH 25

`endif

/* core/fcs_pkg.sv */
// Types for the fan setup register bank.
package fcs_pkg;
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcs_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } fcs_rsp_t;

    typedef struct packed {
        logic       program_enable;
        logic       pwm_fast_clock;
        logic       signed_filter_bits_enable;
        logic       lut_resolution_extend;
        logic       high_res_active;
        logic [7:0] duty;
    } fcs_ctrl_t;
endpackage

/* core/fcs_addr_map.sv */
// Folds mirrored addresses onto their primary register address.
// Assumes a plain 8-bit register address from the bus decoder.
`timescale 1ns/100ps
`default_nettype none
`include "fcs_cfg.svh"
module fcs_addr_map
    import fcs_pkg::*;
(
    input wire logic [7:0] addr_in, // Address as issued
    output logic [7:0] addr_out     // Primary address
);
    // Mirror pairs: (09)->03, (0A)->04, (0B)->05, (0D)->07, (0E)->08
    wire logic is_mirror;
    assign is_mirror = (addr_in == 8'h09) || (addr_in == 8'h0A) || (addr_in == 8'h0B)
        || (addr_in == 8'h0D) || (addr_in == 8'h0E);
    assign addr_out = is_mirror ? (addr_in - 8'h06) : addr_in; // [RULE12]
endmodule
`default_nettype wire

/* core/fcs_regbank.sv */
// Fan setup register bank: enhanced configuration, fan/PWM setup registers,
// program-enable write gate, mirrored addresses and lookup table storage.
// Assumes a serial bus slave in front delivering one-cycle read/write strobes.
//
// Operation
// RULE1: Host waits until power-on not-ready flag is clear before fan setup.
// RULE2: Host selects diode compensation mode in register 30 bit 1.
// RULE3: Host writes tach options, PWM clock select and polarity in 4A.
// RULE4: Host programs spin-up behaviour in register 4B bits 0 to 5.
// RULE5: Host writes PWM frequency bits 0 to 4 of register 4D.
// RULE6: Smoothing and extended duty resolution work only at 22.5 kHz.
// RULE7: Host writes either the lookup table and offset, or duty value.
// RULE8: Duty value uses bits 0-5, or 0-7 with extended resolution.
// RULE9: Host ends lookup-table setup by clearing program enable.
// RULE10: Fan setup registers accept writes only while program enable is set.
// RULE11: After setup, remaining registers may be written in any order.
// RULE12: Mirrored addresses reach the same register for reads and writes.
// RULE13: Enhanced configuration bit 7 always reads zero.
// RULE14: Signed low byte bits 4:3 read zero unless filter bits enabled.
// RULE15: Enhanced bit 5 selects 7-bit or 8-bit lookup temperature resolution.
`timescale 1ns/100ps
`default_nettype none
`include "fcs_cfg.svh"
module fcs_regbank
    import fcs_pkg::*;
#(
    parameter int LUT_DEPTH = `FCS_LUT_DEPTH
)(
    input wire logic clk,              // 100 MHz clock
    input wire logic sys_rst,          // Synchronous reset, active high
    input wire fcs_req_t req,          // Register request strobes
    input wire logic not_ready,        // Power-on not-ready, same domain
    input wire logic filter_on,        // Digital filter enabled
    input wire logic [7:0] slsb_raw,   // Raw remote signed temperature low byte
    input wire logic [7:0] lut_temp,   // Remote temp for lookup, 0.5 C LSB
    output fcs_rsp_t rsp,              // Read answer, one cycle after strobe
    output fcs_ctrl_t ctrl,            // Fan control settings
    output logic [7:0] lut_index_temp  // Temperature as lookup-table compares it
);
    logic [7:0] enh, prc, spin, freq, duty, lofs, trut, conf;
    logic [7:0] lut_mem [LUT_DEPTH];
    logic [7:0] por_status;
    wire logic [7:0] addr;

    fcs_addr_map u_map (
        .addr_in(req.addr),
        .addr_out(addr)
    );

    wire logic pgm = prc[`FCS_BIT_PGM];
    wire logic wr = req.we;
    wire logic fan_wr = wr && pgm; // [RULE10]
    wire logic hit_enh = (addr == `FCS_ADDR_ENH);
    wire logic hit_prc = (addr == `FCS_ADDR_PRC);
    wire logic hit_spin = (addr == `FCS_ADDR_SPIN);
    wire logic hit_freq = (addr == `FCS_ADDR_FREQ);
    wire logic hit_duty = (addr == `FCS_ADDR_DUTY);
    wire logic hit_lofs = (addr == `FCS_ADDR_LOFS);
    wire logic hit_true = (addr == `FCS_ADDR_TRUE);
    wire logic hit_conf = (addr == `FCS_ADDR_CONF);
    wire logic hit_lut = (addr >= `FCS_ADDR_LUT_LO) && (addr <= `FCS_ADDR_LUT_HI);
    wire logic [7:0] lut_off = addr - `FCS_ADDR_LUT_LO;

    // Extended duty resolution only exists at the 22.5 kHz setting
    wire logic at_highres_freq = (freq[4:0] == `FCS_FREQ_HIGHRES) && !prc[`FCS_BIT_CLKSEL];
    wire logic hires = enh[`FCS_BIT_HIRES] && at_highres_freq; // [RULE6]
    wire logic [7:0] duty_mask = hires ? `FCS_MASK_DUTY_HI : `FCS_MASK_DUTY_LO; // [RULE8]

    // 4A bit 5 itself must stay writable or program enable could never be set again once cleared
    wire logic [7:0] next_prc = (prc & ~`FCS_MASK_PRC) | (req.wdata & `FCS_MASK_PRC)
        | {2'b00, req.wdata[`FCS_BIT_PGM], 5'b00000};
    wire logic [7:0] prc_keep = {prc[7:6], 1'b0, prc[4:0]};
    wire logic [7:0] next_prc_w = pgm ? next_prc : (prc_keep | {2'b00, req.wdata[5], 5'b0});

    // Read-side views
    wire logic [7:0] enh_rd = enh & `FCS_MASK_ENH; // [RULE13]
    wire logic [7:0] slsb_rd = (enh[`FCS_BIT_SFBE] && filter_on) ? slsb_raw
        : (slsb_raw & ~`FCS_MASK_SLSB_FILT); // [RULE14]

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (1'b1)
            hit_enh: rd_mux = enh_rd;
            hit_prc: rd_mux = prc;
            hit_spin: rd_mux = spin;
            hit_freq: rd_mux = freq;
            hit_duty: rd_mux = duty & duty_mask;
            hit_lofs: rd_mux = lofs;
            hit_true: rd_mux = trut;
            hit_conf: rd_mux = conf;
            hit_lut: rd_mux = lut_mem[lut_off[4:0]];
            (addr == `FCS_ADDR_SLSB): rd_mux = slsb_rd;
            (addr == `FCS_ADDR_POR): rd_mux = por_status;
            default: rd_mux = 8'h00;
        endcase
    end

    // Lookup compare temperature: whole degrees unless extended
    wire logic [7:0] next_lut_temp = enh[`FCS_BIT_LUT_RESOLUTION_EXTEND] ? lut_temp
        : {1'b0, lut_temp[7:1]}; // [RULE15]

    always_ff @(posedge clk) begin
        por_status <= {not_ready, 7'h00};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enh <= `FCS_RST_ENH;
            prc <= `FCS_RST_PRC;
            spin <= `FCS_RST_SPIN;
            freq <= `FCS_RST_FREQ;
            duty <= `FCS_RST_DUTY;
            lofs <= `FCS_RST_LOFS;
        end else begin
            if (hit_prc && wr) prc <= next_prc_w;
            if (hit_enh && fan_wr) enh <= req.wdata & `FCS_MASK_ENH; // [RULE10]
            if (hit_spin && fan_wr) spin <= req.wdata & `FCS_MASK_SPIN;
            if (hit_freq && fan_wr) freq <= req.wdata & `FCS_MASK_FREQ;
            if (hit_duty && fan_wr) duty <= req.wdata & duty_mask; // [RULE8]
            if (hit_lofs && fan_wr) lofs <= req.wdata;
        end
    end

    // Lookup table has no reset; host loads it during setup
    always_ff @(posedge clk) begin
        if (hit_lut && fan_wr) lut_mem[lut_off[4:0]] <= req.wdata;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trut <= `FCS_RST_TRUE;
            conf <= `FCS_RST_CONF;
        end else begin
            if (hit_true && wr) trut <= req.wdata; // [RULE2]
            if (hit_conf && wr) conf <= req.wdata; // [RULE12]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp <= '0;
            ctrl <= '0;
            lut_index_temp <= 8'h00;
        end else begin
            rsp.valid <= req.re;
            rsp.rdata <= req.re ? rd_mux : 8'h00;
            ctrl.program_enable <= pgm;
            ctrl.pwm_fast_clock <= prc[`FCS_BIT_CLKSEL];
            ctrl.signed_filter_bits_enable <= enh[`FCS_BIT_SFBE];
            ctrl.lut_resolution_extend <= enh[`FCS_BIT_LUT_RESOLUTION_EXTEND];
            ctrl.high_res_active <= hires; // [RULE6]
            ctrl.duty <= duty & duty_mask;
            lut_index_temp <= next_lut_temp;
        end
    end
endmodule
`default_nettype wire

/* verification/fcs_regbank_checker.sv */
// Port-level properties of the fan setup register bank.
// Bound to fcs_regbank; reads its ports only.
`timescale 1ns/100ps
`default_nettype none
module fcs_regbank_checker
    import fcs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire fcs_req_t req, // Strobes
    input wire logic filter_on, // Filter level
    input wire logic [7:0] lut_temp, // Lookup temp
    input wire fcs_rsp_t rsp, // Read answer
    input wire fcs_ctrl_t ctrl, // Settings
    input wire logic [7:0] lut_index_temp // Compared temp
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_res7; req.re && req.addr == 8'h45 |=> rsp.valid && !rsp.rdata[7]; endproperty
    a_res7: assert property (p_res7) else $error("reserved bit set");
    property p_filt; req.re && req.addr == 8'h10 && !filter_on |=> rsp.rdata[4:3] == 2'b00;
    endproperty
    a_filt: assert property (p_filt) else $error("filter bits leak");
    // Skip the edge after reset: registered outputs still hold reset zeros
    property p_lut_resolution_extend; !$past(sys_rst) |-> lut_index_temp ==
        (ctrl.lut_resolution_extend ? $past(lut_temp) : $past(lut_temp) >> 1); endproperty
    a_lut_resolution_extend: assert property (p_lut_resolution_extend) else $error("lookup temp scale");
    property p_gate; !ctrl.program_enable && !$past(req.we) && req.we && req.addr == 8'h4C
        |=> ##1 $stable(ctrl.duty); endproperty
    a_gate: assert property (p_gate) else $error("gated write taken");
    property p_duty; !ctrl.high_res_active |-> ctrl.duty[7:6] == 2'b00; endproperty
    a_duty: assert property (p_duty) else $error("duty too wide");
    property p_hres; ctrl.high_res_active |-> !ctrl.pwm_fast_clock; endproperty
    a_hres: assert property (p_hres) else $error("high res on fast clock");
    property p_mirror; req.we && req.addr == 8'h09 ##2 req.re && req.addr == 8'h03
        |=> rsp.rdata == $past(req.wdata, 3); endproperty
    a_mirror: assert property (p_mirror) else $error("mirror mismatch");
    c_refused: cover property (req.we && !ctrl.program_enable);
    c_hires: cover property (ctrl.high_res_active);
    c_mirror: cover property (req.re && req.addr == 8'h03);
endmodule
bind fcs_regbank fcs_regbank_checker i_chk (.clk(clk), .sys_rst(sys_rst), .req(req),
    .filter_on(filter_on), .lut_temp(lut_temp), .rsp(rsp), .ctrl(ctrl),
    .lut_index_temp(lut_index_temp));
`default_nettype wire

/* verification/fcs_host_model.sv */
// Host firmware model issuing single-byte register reads and writes.
// Assumes the bank answers one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module fcs_host_model
    import fcs_pkg::*;
(
    input wire logic clk, // Bank clock
    input wire fcs_rsp_t rsp, // Read answer
    output var fcs_req_t req // Strobes
);
    initial req = '0;
    // Idle address and data inverted so stale values are never trusted
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        req <= {2'b10, a, v};
        @(negedge clk);
        req <= {2'b00, ~a, ~v};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        req <= {2'b01, a, 8'h00};
        @(negedge clk);
        v = rsp.valid ? rsp.rdata : 8'hXX;
        req <= {2'b00, ~a, 8'hFF};
    endtask
endmodule
`default_nettype wire

/* verification/tb_fcs_regbank.sv */
// Self-checking bench for the fan setup register bank.
// Host model drives the strobe bus; bench drives sensor inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_fcs_regbank;
    import fcs_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic not_ready = 1'b1;
    logic filter_on = 1'b1;
    logic [7:0] slsb_raw = 8'hFF;
    logic [7:0] lut_temp = 8'h9B;
    logic [7:0] lut_index_temp;
    logic [7:0] d;
    fcs_req_t req;
    fcs_rsp_t rsp;
    fcs_ctrl_t ctrl;
    int miscompares = 0;
    int checked = 0;
    logic [15:0] rst_tab [8] = '{16'h4500, 16'h4A20, 16'h4B3F, 16'h4D17,
        16'h4C00, 16'h4E00, 16'h3002, 16'h0300};
    always #5 clk = ~clk;
    fcs_regbank i_fcs_regbank (.clk(clk), .sys_rst(sys_rst), .req(req),
        .not_ready(not_ready), .filter_on(filter_on), .slsb_raw(slsb_raw),
        .lut_temp(lut_temp), .rsp(rsp), .ctrl(ctrl), .lut_index_temp(lut_index_temp));
    fcs_host_model u_host (.clk(clk), .rsp(rsp), .req(req));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (24) @(negedge clk);
        not_ready <= 1'b0;
    end
    initial begin
        repeat (4) @(negedge clk);
        sys_rst <= 1'b0;
        d = 8'h80;
        for (int i = 0; i < 40 && d[7]; i++) u_host.rd(8'h33, d);
        chk(d & 8'h80, 8'h00);
        // Never left ready: no point in configuring
        if (d[7]) conclude();
        for (int i = 0; i < 8; i++) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
        // First pass: direct duty value chosen, lookup table left alone
        u_host.wr(8'h30, 8'h00);
        rchk(8'h30, 8'h00);
        u_host.wr(8'h4A, 8'h33);
        rchk(8'h4A, 8'h33);
        chk(ctrl.pwm_fast_clock, 8'h00);
        u_host.wr(8'h4B, 8'h05);
        u_host.wr(8'h4D, 8'h17);
        u_host.wr(8'h45, 8'hFF);
        rchk(8'h45, 8'h7F);
        chk(ctrl.high_res_active, 8'h01);
        chk(ctrl.signed_filter_bits_enable, 8'h01);
        u_host.wr(8'h4C, 8'hC5);
        rchk(8'h4B, 8'h05);
        chk(ctrl.duty, 8'hC5);
        u_host.wr(8'h4D, 8'h16);
        rchk(8'h4D, 8'h16);
        chk(ctrl.duty, 8'h05);
        chk(ctrl.high_res_active, 8'h00);
        chk(lut_index_temp, 8'h9B);
        rchk(8'h10, 8'hFF);
        u_host.wr(8'h45, 8'h00);
        filter_on <= 1'b0;
        rchk(8'h10, 8'hE7);
        chk(lut_index_temp, 8'h4D);
        chk(ctrl.lut_resolution_extend, 8'h00);
        u_host.wr(8'h09, 8'hA5);
        rchk(8'h03, 8'hA5);
        rchk(8'h09, 8'hA5);
        u_host.wr(8'h4A, 8'h13);
        rchk(8'h4A, 8'h13);
        chk(ctrl.program_enable, 8'h00);
        u_host.wr(8'h4A, 8'h08);
        u_host.wr(8'h4C, 8'h3F);
        u_host.wr(8'h4D, 8'h01);
        rchk(8'h4D, 8'h16);
        chk(ctrl.duty, 8'h05);
        rchk(8'h4A, 8'h13);
        rchk(8'h40, 8'h00);
        // Reset in mid-run, then a second pass with the lookup table
        sys_rst <= 1'b1;
        repeat (4) @(negedge clk);
        sys_rst <= 1'b0;
        rchk(8'h4C, 8'h00);
        chk(ctrl.duty, 8'h00);
        rchk(8'h4A, 8'h20);
        rchk(8'h45, 8'h00);
        rchk(8'h03, 8'h00);
        u_host.wr(8'h30, 8'h02);
        u_host.wr(8'h4A, 8'h3B);
        rchk(8'h4A, 8'h3B);
        chk(ctrl.pwm_fast_clock, 8'h01);
        u_host.wr(8'h4B, 8'h3F);
        u_host.wr(8'h4D, 8'h17);
        u_host.wr(8'h45, 8'h30);
        filter_on <= 1'b1;
        rchk(8'h10, 8'hE7);
        chk(ctrl.high_res_active, 8'h00);
        chk(ctrl.lut_resolution_extend, 8'h01);
        chk(lut_index_temp, 8'h9B);
        u_host.wr(8'h4E, 8'h12);
        u_host.wr(8'h50, 8'h33);
        rchk(8'h4E, 8'h12);
        rchk(8'h50, 8'h33);
        u_host.wr(8'h4A, 8'h1B);
        rchk(8'h4A, 8'h1B);
        chk(ctrl.program_enable, 8'h00);
        u_host.wr(8'h50, 8'h77);
        u_host.wr(8'h45, 8'h00);
        rchk(8'h50, 8'h33);
        rchk(8'h45, 8'h30);
        conclude();
    end
endmodule
`default_nettype wire
